// >>> logic/dsa_map.svh
// Register offsets, field positions and reset values of the diskette status block
`ifndef DSA_MAP_SVH
`define DSA_MAP_SVH

`define DSA_OFF_CTRL      8'he0
`define DSA_OFF_DRVCTL    8'he1
`define DSA_OFF_DATA      8'he2
`define DSA_OFF_CRC_HI    8'he3
`define DSA_OFF_CRC_LO    8'he4
`define DSA_OFF_IRQ_STAT  8'he5
`define DSA_OFF_IRQ_MASK  8'he6
`define DSA_OFF_STAT_A    8'he8
`define DSA_OFF_STAT_B    8'he9

`define DSA_CTRL_WRITE    7
`define DSA_CTRL_READ     6
`define DSA_CTRL_DIAG     5
`define DSA_CTRL_CRC_INIT 1
`define DSA_CTRL_CRC_CHK  0

`define DSA_DRV_MFM       6
`define DSA_DRV_FILTER    5
`define DSA_DRV_INNER     4
`define DSA_DRV_HEAD      3
`define DSA_DRV_SIDE      2

`define DSA_IRQ_SERVICE   0
`define DSA_IRQ_OVERRUN   1
`define DSA_IRQ_CRC       2
`define DSA_IRQ_INDEX     3
`define DSA_IRQ_COVER     4

`define DSA_CRC_POLY      16'h1021
`define DSA_CRC_SEED      16'hffff
`define DSA_CRC_GOOD      16'h0000
`define DSA_BYTE_ZERO     8'h00

`endif

// >>> logic/dsa_pkg.sv
// Types shared by the diskette status block
`default_nettype none
package dsa_pkg;

  typedef struct packed {
    logic index;
    logic erase_gate;
    logic disk2;
    logic cover_open;
  } dsa_drv_in_s;

  typedef struct packed {
    logic       mfm;
    logic       filter;
    logic       wr_cur_low;
    logic       rd_comp;
    logic       head_load;
    logic       side;
    logic [1:0] access;
    logic       wr_valid;
    logic [7:0] wr_byte;
  } dsa_drv_out_s;

  typedef struct packed {
    logic         wr_mode;
    logic         rd_mode;
    logic         diag;
    logic         disk2;
    logic         crc_err;
    logic         overrun;
    logic [6:0]   drvctl;
    logic [7:0]   data;
    logic         pending;
    logic [15:0]  crc;
    logic [7:0]   irq_stat;
    logic [7:0]   irq_mask;
    logic [7:0]   rdata;
    logic         irq;
    logic         idx_prev;
    logic         cover_prev;
    dsa_drv_out_s drv;
  } dsa_state_s;

endpackage

`default_nettype wire

// >>> logic/dsa_status.sv
// Diskette adapter status bytes, mode latches, drive control lines and byte service
`timescale 1ns/1ps
`default_nettype none
`include "dsa_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - First byte top bits show write/read/diag latches
// - First byte bit 3 follows index sensor
// - First byte bit 4 follows erase gate
// - Diskette-2 bit sampled at index pulse
// - First byte bit 6 flags CRC mismatch
// - First byte bit 7 flags missed byte service
// - Overrun drops read/write, back to access mode
// - Second byte bit 0 shows cover open
// - Second byte bit 1 selects MFM or FM
// - Filter latch compensates only while reading
// - Inner tracks: low write current, read compensation
// - Head engage bit lowers or raises heads
// - Head select bit picks disk side
// - Last two bits drive the access lines
module dsa_status (
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_stb_i,
  input  wire logic                 rd_stb_i,
  output var  logic [7:0]           rdata_o,
  output var  logic                 irq_o,
  input  wire dsa_pkg::dsa_drv_in_s drv_i,
  input  wire logic                 byte_stb_i,
  input  wire logic [7:0]           rd_byte_i,
  output var  dsa_pkg::dsa_drv_out_s drv_o
);
  import dsa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers

  localparam dsa_state_s RESET_STATE = '{
    crc:     `DSA_CRC_SEED,
    default: '0
  };

  dsa_state_s st_reg;
  dsa_state_s st_next;

  // CRC-16 over one byte, most significant bit first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ b[i])
        c = {c[14:0], 1'b0} ^ `DSA_CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // First status byte, bit 0 in the MSB
  function automatic logic [7:0] stat_a(input dsa_state_s s, input dsa_drv_in_s d);
    return {s.wr_mode, s.rd_mode, s.diag, d.index, d.erase_gate, s.disk2, s.crc_err, s.overrun};
  endfunction

  // Second status byte, bit 0 in the MSB
  function automatic logic [7:0] stat_b(input dsa_state_s s, input dsa_drv_in_s d);
    return {d.cover_open, s.drvctl};
  endfunction

  logic acc_wr;
  logic acc_rd;
  logic busy;
  logic byte_due;
  logic overrun_now;
  logic index_rise;
  logic cover_rise;

  assign acc_wr      = wr_stb_i;
  assign acc_rd      = rd_stb_i;
  assign busy        = st_reg.wr_mode | st_reg.rd_mode;
  assign byte_due    = byte_stb_i & busy;
  assign overrun_now = byte_due & st_reg.pending;
  assign index_rise  = drv_i.index & ~st_reg.idx_prev;
  assign cover_rise  = drv_i.cover_open & ~st_reg.cover_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [7:0] ev;
    logic [7:0] rd_val;
    st_next = st_reg;
    ev      = `DSA_BYTE_ZERO;
    rd_val  = `DSA_BYTE_ZERO;

    st_next.idx_prev   = drv_i.index;
    st_next.cover_prev = drv_i.cover_open;

    // Disk type only trusted once the index has been seen
    if (index_rise)
      st_next.disk2 = drv_i.disk2;

    // Register writes
    if (acc_wr)
    begin
      case (addr_i)
        `DSA_OFF_CTRL:
        begin
          st_next.wr_mode = wdata_i[`DSA_CTRL_WRITE];
          st_next.rd_mode = wdata_i[`DSA_CTRL_READ];
          st_next.diag    = wdata_i[`DSA_CTRL_DIAG];
          st_next.overrun = 1'b0;
          st_next.crc_err = 1'b0;
          // A write needs its first byte before the first slot
          st_next.pending = wdata_i[`DSA_CTRL_WRITE];
          if (wdata_i[`DSA_CTRL_CRC_INIT])
            st_next.crc = `DSA_CRC_SEED;
        end
        `DSA_OFF_DRVCTL:
          st_next.drvctl = wdata_i[6:0];
        `DSA_OFF_DATA:
        begin
          st_next.data = wdata_i;
          if (st_reg.wr_mode)
            st_next.pending = 1'b0;
        end
        `DSA_OFF_IRQ_STAT:
          st_next.irq_stat = st_reg.irq_stat & ~wdata_i;
        `DSA_OFF_IRQ_MASK:
          st_next.irq_mask = wdata_i;
        default:
          st_next = st_next;
      endcase
    end

    // Register reads, answered in the following cycle only
    if (acc_rd)
    begin
      case (addr_i)
        `DSA_OFF_CTRL:     rd_val = {st_reg.wr_mode, st_reg.rd_mode, st_reg.diag, 5'h00};
        `DSA_OFF_DRVCTL:   rd_val = {1'b0, st_reg.drvctl};
        `DSA_OFF_DATA:     rd_val = st_reg.data;
        `DSA_OFF_CRC_HI:   rd_val = st_reg.crc[15:8];
        `DSA_OFF_CRC_LO:   rd_val = st_reg.crc[7:0];
        `DSA_OFF_IRQ_STAT: rd_val = st_reg.irq_stat;
        `DSA_OFF_IRQ_MASK: rd_val = st_reg.irq_mask;
        `DSA_OFF_STAT_A:   rd_val = stat_a(st_reg, drv_i);
        `DSA_OFF_STAT_B:   rd_val = stat_b(st_reg, drv_i);
        default:           rd_val = `DSA_BYTE_ZERO;
      endcase
      if (addr_i == `DSA_OFF_DATA && st_reg.rd_mode)
        st_next.pending = 1'b0;
    end
    st_next.rdata = rd_val;

    // CRC compare on request; a good stream leaves zero remainder
    if (acc_wr && addr_i == `DSA_OFF_CTRL && wdata_i[`DSA_CTRL_CRC_CHK] && st_reg.crc != `DSA_CRC_GOOD)
    begin
      st_next.crc_err          = 1'b1;
      ev[`DSA_IRQ_CRC]         = 1'b1;
    end

    // Byte slot from the drive
    st_next.drv.wr_valid = 1'b0;
    if (overrun_now)
    begin
      st_next.overrun      = 1'b1;
      st_next.wr_mode      = 1'b0;
      st_next.rd_mode      = 1'b0;
      st_next.pending      = 1'b0;
      ev[`DSA_IRQ_OVERRUN] = 1'b1;
    end
    else if (byte_due)
    begin
      st_next.pending      = 1'b1;
      ev[`DSA_IRQ_SERVICE] = 1'b1;
      if (st_reg.rd_mode)
      begin
        st_next.data = rd_byte_i;
        st_next.crc  = crc_step(st_reg.crc, rd_byte_i);
      end
      else
      begin
        st_next.drv.wr_valid = 1'b1;
        st_next.drv.wr_byte  = st_reg.data;
        st_next.crc          = crc_step(st_reg.crc, st_reg.data);
      end
    end

    ev[`DSA_IRQ_INDEX] = index_rise;
    ev[`DSA_IRQ_COVER] = cover_rise;

    // Sticky events; a set beats a same-cycle clear
    st_next.irq_stat = st_next.irq_stat | ev;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

    // Drive control lines, registered
    st_next.drv.mfm        = st_next.drvctl[`DSA_DRV_MFM];
    st_next.drv.filter     = st_next.drvctl[`DSA_DRV_FILTER] & st_next.rd_mode;
    st_next.drv.wr_cur_low = st_next.drvctl[`DSA_DRV_INNER] & st_next.wr_mode;
    st_next.drv.rd_comp    = st_next.drvctl[`DSA_DRV_INNER] & st_next.rd_mode;
    st_next.drv.head_load  = st_next.drvctl[`DSA_DRV_HEAD];
    st_next.drv.side       = st_next.drvctl[`DSA_DRV_SIDE];
    st_next.drv.access     = st_next.drvctl[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_reg <= RESET_STATE;
    else
      st_reg <= st_next;
  end

  assign rdata_o = st_reg.rdata;
  assign irq_o   = st_reg.irq;
  assign drv_o   = st_reg.drv;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_slot_missed;
    byte_stb_i && (st_reg.wr_mode || st_reg.rd_mode) && st_reg.pending;
  endsequence

  sequence s_drv_write;
    wr_stb_i && addr_i == `DSA_OFF_DRVCTL;
  endsequence

  sequence s_read_a;
    rd_stb_i && addr_i == `DSA_OFF_STAT_A;
  endsequence

  sequence s_read_b;
    rd_stb_i && addr_i == `DSA_OFF_STAT_B;
  endsequence

  sequence s_ctrl_write;
    wr_stb_i && addr_i == `DSA_OFF_CTRL;
  endsequence

  sequence s_slot_served;
    byte_stb_i && (st_reg.wr_mode || st_reg.rd_mode) && !st_reg.pending;
  endsequence

  a_overrun_abort: assert property (s_slot_missed |=> st_reg.overrun && !st_reg.rd_mode && !st_reg.wr_mode)
    else $error("overrun did not abort the operation");

  a_overrun_flag: assert property (s_read_a |=> rdata_o[0] == $past(st_reg.overrun))
    else $error("overrun not flagged");

  a_mode_bits: assert property (s_read_a |=> rdata_o[7:5] == $past({st_reg.wr_mode, st_reg.rd_mode, st_reg.diag}))
    else $error("mode latches misreported");

  a_index_bit: assert property (s_read_a |=> rdata_o[4] == $past(drv_i.index))
    else $error("index bit wrong");

  a_erase_bit: assert property (s_read_a |=> rdata_o[3] == $past(drv_i.erase_gate))
    else $error("erase gate bit wrong");

  a_disk2_sample: assert property ($rose(drv_i.index) |=> st_reg.disk2 == $past(drv_i.disk2))
    else $error("disk type not taken at index");

  a_disk2_hold: assert property (!$rose(drv_i.index) |=> $stable(st_reg.disk2))
    else $error("disk type changed away from index");

  a_crc_flag: assert property (wr_stb_i && addr_i == `DSA_OFF_CTRL && wdata_i[`DSA_CTRL_CRC_CHK]
                               && st_reg.crc != `DSA_CRC_GOOD |=> st_reg.crc_err)
    else $error("crc mismatch not flagged");

  a_cover_bit: assert property (s_read_b |=> rdata_o[7] == $past(drv_i.cover_open))
    else $error("cover bit wrong");

  a_head_line: assert property (s_drv_write |=> drv_o.head_load == $past(wdata_i[`DSA_DRV_HEAD])
                                && drv_o.side == $past(wdata_i[`DSA_DRV_SIDE])
                                && drv_o.access == $past(wdata_i[1:0]))
    else $error("drive lines do not follow control write");

  a_mfm_line: assert property (s_drv_write ##1 !(wr_stb_i && addr_i == `DSA_OFF_DRVCTL)
                               |=> drv_o.mfm == $past(wdata_i[`DSA_DRV_MFM], 2))
    else $error("recording mode line wrong");

  a_filter_read: assert property (drv_o.filter |-> st_reg.drvctl[`DSA_DRV_FILTER] && st_reg.rd_mode)
    else $error("filter active without latch");

  a_filter_mode: assert property (!st_reg.rd_mode |-> !drv_o.filter)
    else $error("filter active outside read");

  a_inner_write: assert property (drv_o.wr_cur_low == (st_reg.drvctl[`DSA_DRV_INNER] && st_reg.wr_mode)
                                  && drv_o.rd_comp == (st_reg.drvctl[`DSA_DRV_INNER] && st_reg.rd_mode))
    else $error("inner track lines inconsistent");

  a_rdata_once: assert property (!rd_stb_i |=> rdata_o == `DSA_BYTE_ZERO)
    else $error("read data held beyond its cycle");

  a_irq_level: assert property (##1 irq_o == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("interrupt level wrong");

  // Status bytes as read back
  a_disk2_bit: assert property (s_read_a |=> rdata_o[2] == $past(st_reg.disk2))
    else $error("disk type bit wrong");

  a_crc_bit: assert property (s_read_a |=> rdata_o[1] == $past(st_reg.crc_err))
    else $error("crc error bit wrong");

  a_ctl_bits: assert property (s_read_b |=> rdata_o[6:0] == $past(st_reg.drvctl))
    else $error("drive control bits misreported");

  // Mode latches, CRC seed and sticky error flags
  a_mode_write: assert property (s_ctrl_write ##0 !(byte_stb_i && busy && st_reg.pending)
                                 |=> st_reg.wr_mode == $past(wdata_i[`DSA_CTRL_WRITE])
                                 && st_reg.rd_mode == $past(wdata_i[`DSA_CTRL_READ])
                                 && st_reg.diag == $past(wdata_i[`DSA_CTRL_DIAG]))
    else $error("mode latches not loaded");

  a_crc_clear: assert property (s_ctrl_write ##0 !wdata_i[`DSA_CTRL_CRC_CHK] |=> !st_reg.crc_err)
    else $error("crc error not cleared by control write");

  a_crc_seed: assert property (s_ctrl_write ##0 wdata_i[`DSA_CTRL_CRC_INIT] && !byte_stb_i
                               |=> st_reg.crc == `DSA_CRC_SEED)
    else $error("crc not reseeded");

  a_crc_sticky: assert property (st_reg.crc_err && !(wr_stb_i && addr_i == `DSA_OFF_CTRL)
                                 |=> st_reg.crc_err)
    else $error("crc error dropped on its own");

  a_overrun_sticky: assert property (st_reg.overrun && !(wr_stb_i && addr_i == `DSA_OFF_CTRL)
                                     |=> st_reg.overrun)
    else $error("overrun dropped on its own");

  // Byte slots
  a_read_slot: assert property (s_slot_served ##0 st_reg.rd_mode
                                |=> st_reg.data == $past(rd_byte_i) && st_reg.pending)
    else $error("read byte not taken");

  a_write_slot: assert property (s_slot_served ##0 !st_reg.rd_mode
                                 |=> drv_o.wr_valid && drv_o.wr_byte == $past(st_reg.data))
    else $error("write byte not handed to the drive");

  a_overrun_silent: assert property (s_slot_missed |=> !drv_o.wr_valid)
    else $error("byte given on a missed slot");

  a_wr_pulse: assert property (drv_o.wr_valid |=> !drv_o.wr_valid)
    else $error("write strobe to the drive longer than a cycle");

  a_data_read: assert property (rd_stb_i && addr_i == `DSA_OFF_DATA && st_reg.rd_mode && !byte_stb_i
                                |=> !st_reg.pending)
    else $error("data read did not free the slot");

  a_data_write: assert property (wr_stb_i && addr_i == `DSA_OFF_DATA && st_reg.wr_mode && !byte_stb_i
                                 |=> !st_reg.pending)
    else $error("data write did not free the slot");

  // Events and drive lines
  a_index_event: assert property ($rose(drv_i.index) |=> st_reg.irq_stat[`DSA_IRQ_INDEX])
    else $error("index event not latched");

  a_cover_event: assert property ($rose(drv_i.cover_open) |=> st_reg.irq_stat[`DSA_IRQ_COVER])
    else $error("cover open event not latched");

  a_lines_hold: assert property (!(wr_stb_i && addr_i == `DSA_OFF_DRVCTL)
                                 |=> $stable({drv_o.mfm, drv_o.head_load, drv_o.side, drv_o.access}))
    else $error("drive lines moved without a control write");

endmodule // dsa_status

`default_nettype wire

// >>> tb/dsa_drive_model.sv
// Behavioural diskette drive: sensor levels and byte slots
`timescale 1ns/1ps
`default_nettype none

module dsa_drive_model (
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  input  wire dsa_pkg::dsa_drv_in_s lvl_i,
  input  wire logic                 go_i,
  input  wire logic [7:0]           byte_i,
  output var  dsa_pkg::dsa_drv_in_s drv_o,
  output var  logic                 byte_stb_o,
  output var  logic [7:0]           rd_byte_o
);
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      drv_o <= '0;
      byte_stb_o <= 1'h0;
      rd_byte_o <= 8'h00;
    end
    else
    begin
      drv_o <= lvl_i;
      byte_stb_o <= go_i;
      // Data line not held outside a slot: show the inverse
      rd_byte_o <= go_i ? byte_i : ~rd_byte_o;
    end
  end
endmodule // dsa_drive_model

`default_nettype wire

// >>> tb/dsa_status_test.sv
// Self-checking bench of the diskette status block
`timescale 1ns/1ps
`default_nettype none

module dsa_status_test;
  import dsa_pkg::*;
  logic         mclk_i = 1'h0;
  logic         nrst_i = 1'h0;
  logic [7:0]   addr_i = 8'h00;
  logic [7:0]   wdata_i = 8'h00;
  logic         wr_stb_i = 1'h0;
  logic         rd_stb_i = 1'h0;
  logic [7:0]   rdata_o;
  logic         irq_o;
  dsa_drv_in_s  drv_i;
  dsa_drv_in_s  lvl = '0;
  logic         byte_stb_i;
  logic [7:0]   rd_byte_i;
  dsa_drv_out_s drv_o;
  logic         go = 1'h0;
  logic [7:0]   gbyte = 8'h00;
  logic [15:0]  crc;
  int           err_total = 0;
  int           n_compared = 0;
  int           n_wr_valid = 0;

  always #20 mclk_i = ~mclk_i;

  // Counts bytes handed to the drive
  always @(posedge mclk_i)
    if (drv_o.wr_valid === 1'h1)
      n_wr_valid++;

  dsa_status dsa_status_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rdata_o(rdata_o), .irq_o(irq_o), .drv_i(drv_i),
    .byte_stb_i(byte_stb_i), .rd_byte_i(rd_byte_i), .drv_o(drv_o));
  dsa_drive_model dsa_drive_model_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(lvl), .go_i(go),
    .byte_i(gbyte), .drv_o(drv_i), .byte_stb_o(byte_stb_i), .rd_byte_o(rd_byte_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_stb_i <= 1'h1;
    @(posedge mclk_i);
    wr_stb_i <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_stb_i <= 1'h1;
    @(posedge mclk_i);
    rd_stb_i <= 1'h0;
    #1;
    chk(rdata_o, e);
  endtask

  // One byte slot from the drive, then time for the design to act
  task automatic slot(input logic [7:0] b);
    @(posedge mclk_i);
    go <= 1'h1;
    gbyte <= b;
    @(posedge mclk_i);
    go <= 1'h0;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic chk_drv(input logic [7:0] e);
    chk({drv_o.mfm, drv_o.filter, drv_o.wr_cur_low, drv_o.rd_comp, drv_o.head_load, drv_o.side,
      drv_o.access}, e);
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'h0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    err_total++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'h1;
    rd(8'he8, 8'h00);
    rd(8'he9, 8'h00);
    rd(8'hf0, 8'h00);
    foreach (gbyte[i])
    begin
      if (i > 4)
      begin
        wr(8'he0, 8'h01 << i);
        rd(8'he8, 8'h01 << i);
      end
    end
    wr(8'he8, 8'hff);
    rd(8'he8, 8'h20);
    // Drive control lines in read mode, then write mode
    wr(8'he0, 8'h40);
    wr(8'he1, 8'h2a);
    chk_drv(8'h4a);
    wr(8'he1, 8'h55);
    chk_drv(8'h95);
    rd(8'he9, 8'h55);
    wr(8'he0, 8'h80);
    wr(8'he1, 8'h7f);
    chk_drv(8'haf);
    rd(8'he9, 8'h7f);
    // Write slot served, then a slot missed
    wr(8'he2, 8'h3c);
    slot(8'h00);
    chk(drv_o.wr_byte, 8'h3c);
    chk(n_wr_valid[7:0], 8'h01);
    slot(8'h00);
    rd(8'he8, 8'h01);
    rd(8'he9, 8'h7f);
    chk_drv(8'h8f);
    chk(n_wr_valid[7:0], 8'h01);
    // Sensor levels; diskette 2 only taken at the index edge
    wr(8'he0, 8'h00);
    lvl <= 4'h6;
    rd(8'he8, 8'h08);
    lvl <= 4'he;
    rd(8'he8, 8'h18);
    rd(8'he8, 8'h1c);
    lvl <= 4'h1;
    rd(8'he8, 8'h04);
    rd(8'he9, 8'hff);
    // Byte service interrupt: masked in, cleared, masked out
    wr(8'he5, 8'hff);
    rd(8'he5, 8'h00);
    wr(8'he6, 8'h01);
    wr(8'he0, 8'h42);
    slot(8'ha5);
    rd(8'he2, 8'ha5);
    rd(8'he5, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr(8'he5, 8'h01);
    rd(8'he5, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    wr(8'he6, 8'h00);
    slot(8'h5a);
    rd(8'he2, 8'h5a);
    chk({7'h00, irq_o}, 8'h00);
    // Good stream with its own check value, then a bad one
    wr(8'he0, 8'h42);
    crc = crc_step(16'hffff, 8'ha5);
    slot(8'ha5);
    rd(8'he2, 8'ha5);
    slot(crc[15:8]);
    rd(8'he2, crc[15:8]);
    slot(crc[7:0]);
    rd(8'he2, crc[7:0]);
    wr(8'he0, 8'h41);
    rd(8'he8, 8'h44);
    wr(8'he0, 8'h42);
    slot(8'ha5);
    rd(8'he2, 8'ha5);
    wr(8'he0, 8'h41);
    rd(8'he8, 8'h46);
    finish_test();
  end
endmodule // dsa_status_test

`default_nettype wire
